// >>> lfs_consts.svh
// Register offsets, field positions and reset values for the line fault status block
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
`define LFS_OFS_FAULT_A 8'h08
`define LFS_OFS_FAULT_B 8'h09
`define LFS_RESET_FAULT 8'h00
`define LFS_BIT_SEND 7
`define LFS_BIT_EMPTY 6
`define LFS_BIT_HSUM 5
`define LFS_BIT_OLEN 4
`define LFS_BIT_RSUM 3
`define LFS_BIT_RLEN 2
`define LFS_BIT_FRAME 1
`define LFS_BIT_PARITY 0
`endif

// >>> lfs_fault_status.sv
// Two-channel fault status capture with clear-on-read registers
//
// Overview of operation
// R01 - Reading a status register clears all its flags
// R02 - Bit 7 set on improperly sent message
// R03 - Bit 6 set when queue empty at start
// R04 - Host loads an octet before each cycle
// R05 - Bit 6 only while period timer enabled
// R06 - Bit 5 set on host checksum mismatch
// R07 - Bit 5 checking only when verify enabled
// R08 - Withhold message on checksum fault, timer on
// R09 - Bit 4 set on length field mismatch
// R10 - Bit 4 also on late host fill
// R11 - Host may flush queue and resend
// R12 - Bit 3 set on 6-bit reply checksum mismatch
// R13 - Bit 2 set on reply length mismatch
// R14 - Bit 1 framing fault raises receive interrupt
// R15 - Bit 0 parity fault raises receive interrupt
// R16 - Channels identical, independent, flags sticky until read
`timescale 1ns/10ps
`default_nettype none
`include "lfs_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module lfs_channel (
	input wire logic CLK,
	input wire logic RESETN,
	input wire lfs_pkg::lfs_evt_t evt,
	input wire lfs_pkg::lfs_ctl_t ctl,
	input wire logic rd_clr,
	output logic [7:0] status_r,
	output logic withhold_r,
	output logic rx_irq_r
);
	logic [7:0] set_v;
	logic [7:0] status_nxt;
	logic hsum_bad;

	assign hsum_bad = evt.msg_done && ctl.host_sum_verify
		&& (evt.calc_sum != evt.host_sum); // [R06] [R07]

	always_comb begin
		set_v = 8'h00;
		set_v[`LFS_BIT_SEND] = evt.send_bad; // [R02]
		set_v[`LFS_BIT_EMPTY] = evt.cycle_start && evt.queue_empty
			&& ctl.period_timer_on; // [R03] [R05]
		set_v[`LFS_BIT_HSUM] = hsum_bad;
		set_v[`LFS_BIT_OLEN] = (evt.msg_done
			&& (evt.octet_count != evt.outgoing_length_field))
			|| evt.late_fill_overrun; // [R09] [R10]
		set_v[`LFS_BIT_RSUM] = evt.reply_done
			&& (evt.reply_calc_sum != evt.reply_sum); // [R12]
		set_v[`LFS_BIT_RLEN] = evt.reply_done
			&& (evt.reply_count != evt.expected_reply_length); // [R13]
		set_v[`LFS_BIT_FRAME] = evt.framing_err; // [R14]
		set_v[`LFS_BIT_PARITY] = evt.parity_err; // [R15]
		// Set beats clear so an event during the read is kept
		status_nxt = (rd_clr ? 8'h00 : status_r) | set_v; // [R01] [R16]
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			status_r <= `LFS_RESET_FAULT;
		end else begin
			status_r <= status_nxt;
		end
	end

	// One-cycle pulse to the interrupt register
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_irq_r <= 1'b0;
		end else begin
			rx_irq_r <= evt.framing_err || evt.parity_err; // [R14] [R15]
		end
	end

	// Level held while the message must not go out
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			withhold_r <= 1'b0;
		end else begin
			withhold_r <= status_nxt[`LFS_BIT_HSUM] && ctl.period_timer_on; // [R08]
		end
	end

	// Flags only drop on the read strobe of their own channel
	a_flag_sticky: assert property (@(posedge CLK) disable iff (!RESETN) // [R16]
		(status_r[`LFS_BIT_SEND] && !rd_clr) |=> status_r[`LFS_BIT_SEND])
		else $error("flag lost without read");
	a_read_clears: assert property (@(posedge CLK) disable iff (!RESETN) // [R01]
		(rd_clr && set_v == 8'h00) |=> status_r == 8'h00)
		else $error("read did not clear");
	a_empty_gated: assert property (@(posedge CLK) disable iff (!RESETN) // [R05]
		(!ctl.period_timer_on && evt.cycle_start && evt.queue_empty
		&& !status_r[`LFS_BIT_EMPTY]) |=> !status_r[`LFS_BIT_EMPTY])
		else $error("empty flag without timer");
	a_empty_sets: assert property (@(posedge CLK) disable iff (!RESETN) // [R03]
		(ctl.period_timer_on && evt.cycle_start && evt.queue_empty)
		|=> status_r[`LFS_BIT_EMPTY])
		else $error("empty flag missed");
	a_hsum_gated: assert property (@(posedge CLK) disable iff (!RESETN) // [R07]
		(!ctl.host_sum_verify && !status_r[`LFS_BIT_HSUM])
		|=> !status_r[`LFS_BIT_HSUM])
		else $error("checksum flag while disabled");
	a_hsum_sets: assert property (@(posedge CLK) disable iff (!RESETN) // [R06]
		(ctl.host_sum_verify && evt.msg_done && evt.calc_sum != evt.host_sum)
		|=> status_r[`LFS_BIT_HSUM])
		else $error("checksum flag missed");
	a_withhold_msg: assert property (@(posedge CLK) disable iff (!RESETN) // [R08]
		withhold_r == ($past(ctl.period_timer_on) && status_r[`LFS_BIT_HSUM]))
		else $error("withhold mismatch");
	a_olen_sets: assert property (@(posedge CLK) disable iff (!RESETN) // [R10]
		evt.late_fill_overrun |=> status_r[`LFS_BIT_OLEN])
		else $error("late fill missed");
	a_rlen_sets: assert property (@(posedge CLK) disable iff (!RESETN) // [R13]
		(evt.reply_done && evt.reply_count != evt.expected_reply_length)
		|=> status_r[`LFS_BIT_RLEN])
		else $error("reply length missed");
	a_rsum_sets: assert property (@(posedge CLK) disable iff (!RESETN) // [R12]
		(evt.reply_done && evt.reply_calc_sum != evt.reply_sum)
		|=> status_r[`LFS_BIT_RSUM])
		else $error("reply checksum missed");
	a_rx_irq: assert property (@(posedge CLK) disable iff (!RESETN) // [R14]
		(evt.framing_err || evt.parity_err)
		|=> (rx_irq_r && (status_r[`LFS_BIT_FRAME] || status_r[`LFS_BIT_PARITY])))
		else $error("receive interrupt missed");
	a_send_sets: assert property (@(posedge CLK) disable iff (!RESETN) // [R02]
		evt.send_bad |=> status_r[`LFS_BIT_SEND])
		else $error("send fault missed");
	a_olen_cmp: assert property (@(posedge CLK) disable iff (!RESETN) // [R09]
		(evt.msg_done && evt.octet_count != evt.outgoing_length_field)
		|=> status_r[`LFS_BIT_OLEN])
		else $error("length flag missed");
	a_parity_sets: assert property (@(posedge CLK) disable iff (!RESETN) // [R15]
		evt.parity_err |=> status_r[`LFS_BIT_PARITY])
		else $error("parity flag missed");
	a_set_wins: assert property (@(posedge CLK) disable iff (!RESETN) // [R15]
		(rd_clr && evt.parity_err) |=> status_r[`LFS_BIT_PARITY])
		else $error("event lost during read");
	a_withhold_off: assert property (@(posedge CLK) disable iff (!RESETN) // [R08]
		!ctl.period_timer_on |=> !withhold_r)
		else $error("withhold without timer");
	a_frame_sets: assert property (@(posedge CLK) disable iff (!RESETN) // [R14]
		evt.framing_err |=> status_r[`LFS_BIT_FRAME])
		else $error("framing flag missed");
	a_irq_pulse: assert property (@(posedge CLK) disable iff (!RESETN) // [R15]
		(!evt.framing_err && !evt.parity_err) |=> !rx_irq_r)
		else $error("receive interrupt too long");
endmodule

////////////////////////////////////////////////////////////////////////////////
module lfs_fault_status (
	input wire logic CLK,
	input wire logic RESETN,
	input wire lfs_pkg::lfs_evt_t EVT_A,
	input wire lfs_pkg::lfs_evt_t EVT_B,
	input wire lfs_pkg::lfs_ctl_t CTL_A,
	input wire lfs_pkg::lfs_ctl_t CTL_B,
	input wire logic RD_STB,
	input wire logic [7:0] RD_ADDR,
	output logic [7:0] RD_DATA,
	output logic WITHHOLD_A,
	output logic WITHHOLD_B,
	output logic RECEIVE_FAULT_IRQ_A,
	output logic RECEIVE_FAULT_IRQ_B
);
	logic [7:0] status_a;
	logic [7:0] status_b;
	logic rd_a;
	logic rd_b;

	// Read strobe acts as the clear; unmapped offsets read zero
	assign rd_a = RD_STB && (RD_ADDR == `LFS_OFS_FAULT_A); // [R01]
	assign rd_b = RD_STB && (RD_ADDR == `LFS_OFS_FAULT_B); // [R01]

	// Two identical channels; neither sees the other's strobe
	lfs_channel u_ch_a (
		.CLK(CLK),
		.RESETN(RESETN),
		.evt(EVT_A),
		.ctl(CTL_A),
		.rd_clr(rd_a),
		.status_r(status_a),
		.withhold_r(WITHHOLD_A),
		.rx_irq_r(RECEIVE_FAULT_IRQ_A)
	);
	lfs_channel u_ch_b (
		.CLK(CLK),
		.RESETN(RESETN),
		.evt(EVT_B),
		.ctl(CTL_B),
		.rd_clr(rd_b),
		.status_r(status_b),
		.withhold_r(WITHHOLD_B),
		.rx_irq_r(RECEIVE_FAULT_IRQ_B)
	);

	// Data captured with the pre-clear value, shown next cycle
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RD_DATA <= 8'h00;
		end else if (rd_a) begin
			RD_DATA <= status_a;
		end else if (rd_b) begin
			RD_DATA <= status_b;
		end else if (RD_STB) begin
			RD_DATA <= 8'h00;
		end
	end

	// Read data carries the flags as they stood before the clear
	a_read_data_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R01]
		rd_a |=> RD_DATA == $past(status_a))
		else $error("first channel read data wrong");
	a_read_data_b: assert property (@(posedge CLK) disable iff (!RESETN) // [R16]
		rd_b |=> RD_DATA == $past(status_b))
		else $error("second channel read data wrong");
	a_unmapped_zero: assert property (@(posedge CLK) disable iff (!RESETN) // [R01]
		(RD_STB && !rd_a && !rd_b) |=> RD_DATA == 8'h00)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire

// >>> lfs_line_model.sv
// Line-side and host event source for one channel
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module lfs_line_model (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic GO,
	input wire logic [3:0] KIND,
	output var lfs_pkg::lfs_evt_t EVT
);
	// One whole cycle per GO; the fields fall back to zero when idle
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			EVT <= '0;
		end else begin
			if (GO) begin
				EVT.send_bad <= (KIND == 4'h0);
				EVT.cycle_start <= 1'b1;
				EVT.queue_empty <= (KIND == 4'h1); // Queue loaded first, except for KIND 1
				EVT.msg_done <= 1'b1;
				EVT.calc_sum <= 6'h15;
				EVT.host_sum <= (KIND == 4'h2) ? 6'h2A : 6'h15;
				EVT.octet_count <= 8'h04;
				EVT.outgoing_length_field <= (KIND == 4'h3) ? 8'h03 : 8'h04;
				EVT.late_fill_overrun <= (KIND == 4'h4);
				EVT.reply_done <= 1'b1;
				EVT.reply_calc_sum <= 6'h0C;
				EVT.reply_sum <= (KIND == 4'h5) ? 6'h0D : 6'h0C;
				EVT.reply_count <= 8'h02;
				EVT.expected_reply_length <= (KIND == 4'h6) ? 8'h03 : 8'h02;
				EVT.framing_err <= (KIND == 4'h7);
				EVT.parity_err <= (KIND == 4'h8);
			end else begin
				EVT <= '0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> lfs_pkg.sv
// Types shared by the line fault status block
`default_nettype none
package lfs_pkg;
	// Per-channel detection events and their context, one cycle each
	typedef struct packed {
		logic send_bad;
		logic cycle_start;
		logic queue_empty;
		logic msg_done;
		logic [5:0] calc_sum;
		logic [5:0] host_sum;
		logic [7:0] octet_count;
		logic [7:0] outgoing_length_field;
		logic late_fill_overrun;
		logic reply_done;
		logic [5:0] reply_calc_sum;
		logic [5:0] reply_sum;
		logic [7:0] reply_count;
		logic [7:0] expected_reply_length;
		logic framing_err;
		logic parity_err;
	} lfs_evt_t;
	// Per-channel control bits held elsewhere in the device
	typedef struct packed {
		logic period_timer_on;
		logic host_sum_verify;
	} lfs_ctl_t;
endpackage
`default_nettype wire

// >>> tb_lfs_fault_status.sv
// Self-checking bench for the line fault status block
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb_lfs_fault_status;
	logic clk, resetn, rd_stb, go_a, go_b, wh_a, wh_b, irq_a, irq_b;
	logic [7:0] rd_addr, rd_data;
	logic [3:0] kind;
	lfs_pkg::lfs_evt_t evt_a, evt_b;
	lfs_pkg::lfs_ctl_t ctl_a, ctl_b;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int irqs = 0;
	logic [7:0] bitv [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};

	lfs_line_model u_lfs_line_model_a (.CLK(clk), .RESETN(resetn), .GO(go_a), .KIND(kind),
		.EVT(evt_a));
	lfs_line_model u_lfs_line_model_b (.CLK(clk), .RESETN(resetn), .GO(go_b), .KIND(kind),
		.EVT(evt_b));
	lfs_fault_status u_lfs_fault_status (.CLK(clk), .RESETN(resetn), .EVT_A(evt_a),
		.EVT_B(evt_b), .CTL_A(ctl_a), .CTL_B(ctl_b), .RD_STB(rd_stb), .RD_ADDR(rd_addr),
		.RD_DATA(rd_data), .WITHHOLD_A(wh_a), .WITHHOLD_B(wh_b),
		.RECEIVE_FAULT_IRQ_A(irq_a), .RECEIVE_FAULT_IRQ_B(irq_b));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Pulses are one cycle wide, so count them at every edge
	always @(posedge clk) begin
		cyc++;
		irqs <= irqs + int'(irq_a) + int'(irq_b);
		if (cyc == 6000) begin
			err_count++;
			results();
		end
	end

	task automatic results;
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Data holds until the next strobe, so one spare edge is safe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd_stb <= 1'b1;
		rd_addr <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(posedge clk);
		#1 chk(rd_data, exp);
	endtask

	task automatic fire(input int c, input int k);
		@(posedge clk);
		go_a <= (c == 0);
		go_b <= (c == 1);
		kind <= 4'(k);
		@(posedge clk);
		go_a <= 1'b0;
		go_b <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	initial begin
		{rd_stb, go_a, go_b, resetn} = 4'h0;
		{rd_addr, kind} = 12'h000;
		ctl_a = '1;
		ctl_b = '1;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h00);
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 10; k++) begin
				fire(c, k);
				chk({7'h00, (c == 0) ? wh_a : wh_b}, {7'h00, k == 2});
				rd(8'h08 + 8'(c), bitv[k]);
				rd(8'h09 - 8'(c), 8'h00);
				rd(8'h08 + 8'(c), 8'h00);
			end
		end
		chk(8'(irqs), 8'h04);
		@(posedge clk);
		ctl_a <= '0;
		fire(0, 1);
		fire(0, 2);
		chk({7'h00, wh_a}, 8'h00);
		rd(8'h08, 8'h00);
		fire(0, 8);
		rd(8'h10, 8'h00);
		rd(8'h08, 8'h01);
		chk(8'(irqs), 8'h05);
		// Parity event lands in the clearing cycle and must survive it
		@(posedge clk);
		go_a <= 1'b1;
		kind <= 4'h8;
		@(posedge clk);
		go_a <= 1'b0;
		rd_stb <= 1'b1;
		rd_addr <= 8'h08;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(posedge clk);
		#1 chk(rd_data, 8'h00);
		rd(8'h08, 8'h01);
		fire(1, 3);
		fire(1, 9); // Fault-free cycle; the length flag from kind 3 stays until read
		rd(8'h09, 8'h10);
		rd(8'h09, 8'h00);
		chk(8'(irqs), 8'h06);
		results();
	end
endmodule
`default_nettype wire
